// *** core/soft_start_pkg.sv ***
`default_nettype none
package soft_start_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Structure
  localparam int          CH_COUNT       = 2;           // Independent channels
  localparam int          CODE_W         = 4;           // Width of reference and threshold codes
  localparam logic [3:0]  STEP_COUNT     = 4'hF;        // Equal steps from zero to full scale
  localparam logic [3:0]  EXT_LEAD_STEPS = 4'h3;        // Steps where threshold stays above reference
  localparam logic [3:0]  EXT_FLOOR_CODE = 4'h3;        // Minimum extension threshold code
  localparam logic [3:0]  FULL_SCALE     = 4'hF;        // Adjust code meaning no reduction

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int          CLK_HZ         = 10_000_000;  // System clock rate
  localparam int          SS_TIME_US     = 2000;        // Soft start time, microseconds
  localparam int          FAULT_RETRY_US = 10000;       // Short-to-ground retry period, microseconds
  localparam int          SS_CYCLES      = SS_TIME_US * (CLK_HZ / 1_000_000);
  localparam int          RETRY_CYCLES   = FAULT_RETRY_US * (CLK_HZ / 1_000_000);

  //////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [3:0]  CODE_RESET     = 4'h0;        // Reference code after reset
  localparam logic        CLOOP_RESET    = 1'h1;        // Current loop is always on

  // Channel sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RAMP,
    ST_DONE
  } seq_state_t;

endpackage
`default_nettype wire

// *** core/timer_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// Handshake between a channel sequencer and its step timer
interface timer_if;
  logic clear;        // Restart both counts
  logic run;          // Step count advances while high
  logic step_pulse;   // One cycle at each step boundary
  logic ss_elapsed;   // Soft start time has passed since clear

  modport timer (input clear, input run, output step_pulse, output ss_elapsed);
  modport seq   (output clear, output run, input step_pulse, input ss_elapsed);
endinterface
`default_nettype wire

// *** core/step_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
module step_timer #(
  parameter int STEP_CYCLES = 1333,
  parameter int SS_CYCLES   = 20000
) (
  input wire logic sys_clk,
  input wire logic rstn,
  timer_if.timer   tif
);
  import soft_start_pkg::*;

  localparam int SW = $clog2(STEP_CYCLES + 1);
  localparam int EW = $clog2(SS_CYCLES + 1);

  logic [SW-1:0] step_cnt;     // Cycles within the current step
  logic [EW-1:0] elapsed_cnt;  // Cycles since the last clear
  logic          step_hit;     // Step boundary reached
  logic          ss_hit;       // Soft start time reached

  assign step_hit = tif.run && (step_cnt == SW'(STEP_CYCLES - 1));
  assign ss_hit   = (elapsed_cnt == EW'(SS_CYCLES - 1));

  //////////////////////////////////////////////////////////////////////////////
  // Step count only runs while switching is allowed, so a ramp can stretch
  always_ff @(posedge sys_clk) begin
    if (!rstn || tif.clear) begin
      step_cnt        <= '0;
      tif.step_pulse  <= 1'h0;
    end else begin
      step_cnt        <= step_hit ? '0 : (tif.run ? step_cnt + 1'h1 : step_cnt);
      tif.step_pulse  <= step_hit;
    end
  end

  // Elapsed time runs freely and then sticks
  always_ff @(posedge sys_clk) begin
    if (!rstn || tif.clear) begin
      elapsed_cnt     <= '0;
      tif.ss_elapsed  <= 1'h0;
    end else if (!tif.ss_elapsed) begin
      elapsed_cnt     <= elapsed_cnt + 1'h1;
      tif.ss_elapsed  <= ss_hit;
    end
  end

endmodule
`default_nettype wire

// *** core/soft_start_sequencer.sv ***
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module soft_start_sequencer #(
  parameter int SS_CYCLES    = soft_start_pkg::SS_CYCLES,
  parameter int RETRY_CYCLES = soft_start_pkg::RETRY_CYCLES
) (
  input  wire logic                                                     sys_clk,
  input  wire logic                                                     rstn,
  input  wire logic [soft_start_pkg::CH_COUNT-1:0]                      dimming_input,
  input  wire logic [soft_start_pkg::CH_COUNT-1:0]                      engine_select,
  input  wire logic [soft_start_pkg::CH_COUNT-1:0]                      engine_pwm,
  input  wire logic [soft_start_pkg::CH_COUNT-1:0]                      sense_high_ov,
  input  wire logic [soft_start_pkg::CH_COUNT-1:0]                      voltage_feedback_ov,
  input  wire logic                                                     overtemp,
  input  wire logic                                                     internal_supply_uv,
  input  wire logic [soft_start_pkg::CH_COUNT-1:0]                      short_to_ground,
  input  wire logic [soft_start_pkg::CH_COUNT-1:0]                      below_ext_threshold,
  input  wire logic [soft_start_pkg::CH_COUNT-1:0][soft_start_pkg::CODE_W-1:0] adjust_code,
  input  wire logic [soft_start_pkg::CH_COUNT-1:0]                      voltage_loop_enable,
  input  wire logic [soft_start_pkg::CH_COUNT-1:0]                      feedback_at_reference,
  output var  logic [soft_start_pkg::CH_COUNT-1:0][soft_start_pkg::CODE_W-1:0] reference_code,
  output var  logic [soft_start_pkg::CH_COUNT-1:0][soft_start_pkg::CODE_W-1:0] extension_threshold,
  output var  logic [soft_start_pkg::CH_COUNT-1:0]                      switch_enable,
  output var  logic [soft_start_pkg::CH_COUNT-1:0]                      extension_active,
  output var  logic [soft_start_pkg::CH_COUNT-1:0]                      soft_start_busy,
  output var  logic [soft_start_pkg::CH_COUNT-1:0]                      current_loop_active,
  output var  logic [soft_start_pkg::CH_COUNT-1:0]                      voltage_mode
);
  import soft_start_pkg::*;

  localparam int STEP_CYCLES = SS_CYCLES / int'(STEP_COUNT);  // Round down: ramp never overruns
  localparam int OW          = $clog2(SS_CYCLES + 1);          // On-time counter width
  localparam int RW          = $clog2(RETRY_CYCLES + 1);       // Retry counter width

  // Smaller of two codes
  function automatic logic [3:0] code_min(input logic [3:0] a, input logic [3:0] b);
    code_min = (a < b) ? a : b;
  endfunction

  // Larger of two codes
  function automatic logic [3:0] code_max(input logic [3:0] a, input logic [3:0] b);
    code_max = (a > b) ? a : b;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // One identical sequencer per channel; they share only the overtemp and internal_supply_uv inputs
  // independent channel copies
  for (genvar ch = 0; ch < CH_COUNT; ch++) begin : g_ch
    timer_if      tif ();              // Link to this channel's step timer
    seq_state_t   state;               // Sequencer state
    seq_state_t   next_state;          // Next sequencer state
    logic [2:0]   dim_sync;            // Three-stage pin synchroniser
    logic         dim_level;           // Filtered dimming pin level
    logic         dim_prev;            // Dimming source one cycle ago
    logic         dim_src;             // Selected dimming source
    logic         dim_rise;            // Dimming ON begins
    logic         dim_fall;            // Dimming ON ends
    logic [3:0]   step;                // Ramp step reached so far
    logic [3:0]   next_step;           // Next ramp step
    logic         ext;                 // Extension in progress
    logic         next_ext;            // Next extension state
    logic [OW-1:0] on_cnt;             // Length of the current ON time
    logic         on_short;            // ON time still under soft start time
    logic [RW-1:0] retry_cnt;          // Short-to-ground retry timer
    logic         sg_prev;             // Short flag one cycle ago
    logic         retry_wrap;          // Retry period elapsed with short present
    logic         fault_any;           // Any fault other than a short that restarts the ramp
    logic         restart;             // Restart the ramp this cycle
    logic         low_adjust;          // Adjusted target below threshold floor
    logic         ext_start;           // Extension starts this cycle
    logic         ext_stop;            // Extension stops this cycle
    logic [3:0]   thr_base;            // Threshold before lead-step lift
    logic [3:0]   thr_code;            // Threshold with lead-step lift

    step_timer #(
      .STEP_CYCLES (STEP_CYCLES),
      .SS_CYCLES   (SS_CYCLES)
    ) u_timer (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .tif     (tif.timer)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser; stage one feeds stage two only
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        dim_sync  <= 3'h0;
        dim_level <= 1'h0;
      end else begin
        dim_sync  <= {dim_sync[1:0], dimming_input[ch]};
        // A change counts only once stages two and three agree
        if (dim_sync[1] == dim_sync[2]) begin
          dim_level <= dim_sync[2];
        end
      end
    end

    // Engine output is on this clock already, so it needs no synchroniser
    assign dim_src  = engine_select[ch] ? engine_pwm[ch] : dim_level;
    assign dim_rise = dim_src & ~dim_prev;
    assign dim_fall = ~dim_src & dim_prev;

    ////////////////////////////////////////////////////////////////////////////
    // Fault restarts; comparator and fault inputs are synchronous levels
    // synchronous comparator inputs
    assign fault_any  = sense_high_ov[ch] | voltage_feedback_ov[ch] | overtemp | internal_supply_uv;
    assign retry_wrap = short_to_ground[ch] && (retry_cnt == RW'(RETRY_CYCLES - 1));
    assign restart    = (state != ST_IDLE) &&
                        (fault_any || (short_to_ground[ch] && !sg_prev) || retry_wrap);

    // Retry timer runs only while the short persists; it is also cleared in the
    // short's first cycle, so the first retry period is as long as the rest
    always_ff @(posedge sys_clk) begin
      if (!rstn || !short_to_ground[ch] || !sg_prev || retry_wrap) begin
        retry_cnt <= '0;
      end else begin
        retry_cnt <= retry_cnt + 1'h1;
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ramp sequencing
    always_comb begin
      next_state = state;
      next_step  = step;
      if (state == ST_IDLE) begin
        if (dim_rise) begin
          next_state = ST_RAMP;
        end
      end else if (restart) begin
        // Held at zero while a fault other than a short stays present
        next_state = ST_RAMP;
        next_step  = CODE_RESET;
      end else if (state == ST_RAMP && tif.step_pulse) begin
        next_step  = step + 4'h1;
        if (step == STEP_COUNT - 4'h1) begin
          next_state = ST_DONE;
        end
      end
    end

    // Timer is cleared on arming and on every restart
    assign tif.clear = restart || (state == ST_IDLE);
    assign tif.run   = (state == ST_RAMP) && (dim_src || ext);

    ////////////////////////////////////////////////////////////////////////////
    // ON-time extension
    assign on_short   = (on_cnt < OW'(SS_CYCLES));
    assign low_adjust = (adjust_code[ch] < EXT_FLOOR_CODE);
    assign ext_start  = (state == ST_RAMP) && !restart && dim_fall && on_short &&
                        below_ext_threshold[ch] && !(low_adjust && tif.ss_elapsed);
    assign ext_stop   = !below_ext_threshold[ch] || (low_adjust && tif.ss_elapsed) ||
                        restart || (state != ST_RAMP);
    assign next_ext   = ext ? !ext_stop : ext_start;

    // ON time length, saturating just past the soft start time
    always_ff @(posedge sys_clk) begin
      if (!rstn || dim_rise) begin
        on_cnt <= '0;
      end else if (dim_src && on_short) begin
        on_cnt <= on_cnt + 1'h1;
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Extension threshold
    // follows adjust, floored
    assign thr_base = code_max(adjust_code[ch], EXT_FLOOR_CODE);
    assign thr_code = (step < EXT_LEAD_STEPS) ? code_max(thr_base, step + 4'h1) : thr_base;

    ////////////////////////////////////////////////////////////////////////////
    // State and output registers
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        state                   <= ST_IDLE;
        step                    <= CODE_RESET;
        ext                     <= 1'h0;
        dim_prev                <= 1'h0;
        sg_prev                 <= 1'h0;
        reference_code[ch]      <= CODE_RESET;
        extension_threshold[ch] <= CODE_RESET;
        switch_enable[ch]       <= 1'h0;
        extension_active[ch]    <= 1'h0;
        soft_start_busy[ch]     <= 1'h0;
        current_loop_active[ch] <= CLOOP_RESET;
        voltage_mode[ch]        <= 1'h0;
      end else begin
        state                   <= next_state;
        step                    <= next_step;
        ext                     <= next_ext;
        dim_prev                <= dim_src;
        sg_prev                 <= short_to_ground[ch];
        reference_code[ch]      <= code_min(next_step, adjust_code[ch]);
        extension_threshold[ch] <= thr_code;
        switch_enable[ch]       <= (next_state != ST_IDLE) && (dim_src || next_ext);
        extension_active[ch]    <= next_ext;
        soft_start_busy[ch]     <= (next_state == ST_RAMP);
        current_loop_active[ch] <= CLOOP_RESET;
        voltage_mode[ch]        <= voltage_loop_enable[ch] && !restart &&
                                   (voltage_mode[ch] || feedback_at_reference[ch]);
      end
    end
  end

endmodule
`default_nettype wire

// *** test/analog_loop_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Far side: sensed current that builds while switching, and its comparators
module analog_loop_model
  import soft_start_pkg::*;
#(
  parameter int C = CH_COUNT,
  parameter int W = CODE_W
) (
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  input  wire logic [C-1:0]        switch_enable,
  input  wire logic [C-1:0][W-1:0] extension_threshold,
  output var  logic [C-1:0]        below_ext_threshold,
  output var  logic [C-1:0]        feedback_at_reference
);
  logic [C-1:0][7:0] sensed;  // Sensed level in eighths of a step

  //////////////////////////////////////////////////////////////////////////////
  // Slow rise while on, slow decay while off, so short pulses never reach target
  // registered comparator bits
  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < C; c++) begin
      if (!rstn) begin
        sensed[c] <= 8'h00;
        below_ext_threshold[c] <= 1'h0;
        feedback_at_reference[c] <= 1'h0;
      end else begin
        if (switch_enable[c] && sensed[c] < 8'h7F) sensed[c] <= sensed[c] + 8'h01;
        else if (!switch_enable[c] && sensed[c] != 8'h00) sensed[c] <= sensed[c] - 8'h01;
        below_ext_threshold[c] <= sensed[c] < {1'h0, extension_threshold[c], 3'h0};
        feedback_at_reference[c] <= sensed[c] >= 8'h78;  // Output near full scale
      end
    end
  end
endmodule
`default_nettype wire

// *** test/soft_start_sequencer_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
// Port-level checks on the sequencer
module soft_start_sequencer_checker
  import soft_start_pkg::*;
#(
  parameter int C = CH_COUNT,
  parameter int W = CODE_W
) (
  input wire logic                sys_clk,
  input wire logic                rstn,
  input wire logic [C-1:0]        sense_high_ov,
  input wire logic                overtemp,
  input wire logic [C-1:0]        below_ext_threshold,
  input wire logic [C-1:0][W-1:0] adjust_code,
  input wire logic [C-1:0]        voltage_loop_enable,
  input wire logic [C-1:0]        feedback_at_reference,
  input wire logic [C-1:0][W-1:0] reference_code,
  input wire logic [C-1:0][W-1:0] extension_threshold,
  input wire logic [C-1:0]        switch_enable,
  input wire logic [C-1:0]        extension_active,
  input wire logic [C-1:0]        soft_start_busy,
  input wire logic [C-1:0]        current_loop_active,
  input wire logic [C-1:0]        voltage_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////////////
  // loop always on
  a_cloop_always: assert property (current_loop_active == '1)
    else $error("current loop dropped");
  a_ref_clamp: assert property (reference_code[0] <= $past(adjust_code[0]))
    else $error("reference above adjust");
  a_ref_step: assert property (reference_code[0] > $past(reference_code[0])
    |-> reference_code[0] == $past(reference_code[0]) + 4'h1) else $error("reference jumped");
  a_thr_floor: assert property (soft_start_busy[0] && $past(soft_start_busy[0]) |->
    extension_threshold[0] >= EXT_FLOOR_CODE && extension_threshold[0] >= $past(adjust_code[0]))
    else $error("threshold under floor");
  a_thr_lead: assert property (soft_start_busy[0] && $past(soft_start_busy[0]) &&
    reference_code[0] < EXT_LEAD_STEPS |-> extension_threshold[0] > reference_code[0])
    else $error("threshold not above reference");
  a_ext_cause: assert property ($rose(extension_active[1]) |-> $past(below_ext_threshold[1]))
    else $error("extension without low current");
  a_ext_switch: assert property (extension_active[1] && $past(extension_active[1]) |-> switch_enable[1])
    else $error("extension without switching");
  a_vmode_cause: assert property ($rose(voltage_mode[0]) |->
    $past(feedback_at_reference[0] && voltage_loop_enable[0])) else $error("voltage mode uncaused");
  a_fault_hold: assert property ((sense_high_ov[0] || overtemp) [*2] |=> reference_code[0] == 4'h0)
    else $error("ramp moved under fault");
endmodule
bind soft_start_sequencer soft_start_sequencer_checker chk (
  .sys_clk(sys_clk), .rstn(rstn), .sense_high_ov(sense_high_ov), .overtemp(overtemp),
  .below_ext_threshold(below_ext_threshold), .adjust_code(adjust_code), .voltage_loop_enable(voltage_loop_enable),
  .feedback_at_reference(feedback_at_reference), .reference_code(reference_code),
  .extension_threshold(extension_threshold), .switch_enable(switch_enable), .extension_active(extension_active),
  .soft_start_busy(soft_start_busy), .current_loop_active(current_loop_active), .voltage_mode(voltage_mode)
);
`default_nettype wire

// *** test/soft_start_sequencer_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module soft_start_sequencer_tb;
  import soft_start_pkg::*;
  localparam int SS = 150;  // Short soft start keeps the run brief
  localparam int RT = 400;  // Short retry period
  localparam int STEP = SS / 15;
  logic sys_clk = 1'h0;
  logic rstn = 1'h0;
  logic overtemp, internal_supply_uv;
  logic [1:0] dimming_input, engine_select, engine_pwm, sense_high_ov, voltage_feedback_ov, short_to_ground;
  logic [1:0] voltage_loop_enable, below_ext_threshold, feedback_at_reference, switch_enable;
  logic [1:0] extension_active, soft_start_busy, current_loop_active, voltage_mode;
  logic [1:0][3:0] adjust_code, reference_code, extension_threshold;
  int n_mismatch = 0;
  int compares = 0;

  always #50 sys_clk = ~sys_clk;
  soft_start_sequencer #(.SS_CYCLES(SS), .RETRY_CYCLES(RT)) dut (.sys_clk(sys_clk), .rstn(rstn),
    .dimming_input(dimming_input), .engine_select(engine_select), .engine_pwm(engine_pwm),
    .sense_high_ov(sense_high_ov), .voltage_feedback_ov(voltage_feedback_ov), .overtemp(overtemp),
    .internal_supply_uv(internal_supply_uv), .short_to_ground(short_to_ground),
    .below_ext_threshold(below_ext_threshold), .adjust_code(adjust_code),
    .voltage_loop_enable(voltage_loop_enable), .feedback_at_reference(feedback_at_reference),
    .reference_code(reference_code), .extension_threshold(extension_threshold), .switch_enable(switch_enable),
    .extension_active(extension_active), .soft_start_busy(soft_start_busy),
    .current_loop_active(current_loop_active), .voltage_mode(voltage_mode));
  analog_loop_model far (.sys_clk(sys_clk), .rstn(rstn), .switch_enable(switch_enable),
    .extension_threshold(extension_threshold), .below_ext_threshold(below_ext_threshold),
    .feedback_at_reference(feedback_at_reference));

  //////////////////////////////////////////////////////////////////////////////
  // Helpers; reads right after an edge see the settled values of the cycle before
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic set_fault(input int f, input logic v);
    case (f)
      0: sense_high_ov[0] <= v;
      1: voltage_feedback_ov[0] <= v;
      2: overtemp <= v;
      3: internal_supply_uv <= v;
      default: short_to_ground[0] <= v;
    endcase
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_ramp();
    int k;
    int steps;
    logic [3:0] prev;
    steps = 0;
    prev = 4'h0;
    check(reference_code, 8'h00, "reset codes");
    check({soft_start_busy, extension_active, switch_enable, voltage_mode}, 8'h00, "reset flags");
    engine_select <= 2'h1;
    engine_pwm <= 2'h1;
    for (k = 0; k < 20 && soft_start_busy[0] !== 1'h1; k++) tick(1);
    check(soft_start_busy[0], 1'h1, "engine arm");
    for (k = 0; k < 400 && soft_start_busy[0] === 1'h1; k++) begin
      tick(1);
      if (reference_code[0] !== prev) steps++;
      prev = reference_code[0];
    end
    tick(3);
    if (reference_code[0] !== prev) steps++;
    check(steps, 15, "step count");
    check(reference_code[0], 4'hF, "full scale");
    check(k >= SS - STEP && k <= SS + STEP, 1'h1, "ramp length");
    check({reference_code[1], soft_start_busy[1]}, 5'h00, "other channel idle");
    $display("t_ramp done");
  endtask

  // Each restart source, with a lowered target set during the fault
  task automatic t_faults();
    int k;
    int hit;
    for (int f = 0; f < 5; f++) begin
      set_fault(f, 1'h1);
      tick(1);
      adjust_code[0] <= 4'h6;
      tick(2);
      set_fault(f, 1'h0);
      tick(2);
      check({reference_code[0], soft_start_busy[0]}, 5'h01, "restarted");
      hit = 0;
      for (k = 0; k < 400 && soft_start_busy[0] === 1'h1; k++) begin
        tick(1);
        if (reference_code[0] === 4'h6 && hit == 0) hit = k;
      end
      check(hit > 0 && hit < k, 1'h1, "target before end");
      check(reference_code[0], 4'h6, "adjusted level");
    end
    $display("t_faults done");
  endtask

  // Held short restarts once per retry period
  task automatic t_retry();
    int drops;
    int first;
    int last;
    logic [3:0] prev;
    drops = 0;
    first = -1;
    last = 0;
    prev = reference_code[0];
    short_to_ground[0] <= 1'h1;
    for (int k = 0; k < 2 * RT + RT / 2; k++) begin
      tick(1);
      if (reference_code[0] === 4'h0 && prev !== 4'h0) begin
        drops++;
        if (first < 0) first = k;
        last = k;
      end
      prev = reference_code[0];
    end
    short_to_ground[0] <= 1'h0;
    check(drops, 3, "retry restarts");
    check(last - first == 2 * RT, 1'h1, "retry spacing");
    tick(SS + 30);
    $display("t_retry done");
  endtask

  task automatic t_vmode();
    voltage_loop_enable[0] <= 1'h1;
    tick(4);
    check(voltage_mode, 2'h1, "voltage takeover");
    voltage_loop_enable[0] <= 1'h0;
    tick(4);
    check({voltage_mode, current_loop_active}, 4'h3, "voltage loop off");
    $display("t_vmode done");
  endtask

  // Short pin pulses on channel 1: extensions, retrigger, progress only while switching
  task automatic t_ext();
    int starts;
    int bad;
    int idle;
    logic was;
    logic [3:0] prev;
    starts = 0;
    bad = 0;
    idle = 0;
    was = 1'h0;
    prev = 4'h0;
    for (int p = 0; p < 30; p++) begin
      dimming_input[1] <= 1'h1;
      tick(5);
      dimming_input[1] <= 1'h0;
      for (int k = 0; k < 45; k++) begin
        tick(1);
        if (extension_active[1] === 1'h1 && !was) starts++;
        was = extension_active[1];
        idle = (switch_enable[1] === 1'h1) ? 0 : idle + 1;
        if (idle > 3 && reference_code[1] !== prev) bad++;
        prev = reference_code[1];
      end
    end
    check(starts >= 2, 1'h1, "extension retrigger");
    check(bad, 0, "steps while off");
    check({reference_code[1], soft_start_busy[1]}, 5'h1E, "ramp completes");
    check(reference_code[0], 4'h6, "channel 0 untouched");
    // Low adjust on channel 0: reference follows it down, threshold stays on its floor
    adjust_code[0] <= 4'h2;
    tick(3);
    check({reference_code[0], extension_threshold[0]}, 8'h23, "threshold floor");
    $display("t_ext done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {dimming_input, engine_select, engine_pwm, sense_high_ov, voltage_feedback_ov} = '0;
    {short_to_ground, voltage_loop_enable, overtemp, internal_supply_uv} = '0;
    adjust_code = 8'hFF;
    tick(10);
    rstn <= 1'h1;
    tick(2);
    t_ramp();
    t_faults();
    t_retry();
    t_vmode();
    t_ext();
    summarize();
  end

  // Watchdog: the sequence needs about 4000 cycles
  initial begin
    tick(8000);
    n_mismatch++;
    $display("ERROR %0t watchdog expired", $time);
    summarize();
  end
endmodule
`default_nettype wire
